//--- shared/vcal_pkg.sv
package vcal_pkg;
    // ----------------------------------------
    // Register indices (byte address = 4 x index)
    // ----------------------------------------
    localparam logic [9:0] IDX_CAL_CTRL = 10'h018;
    localparam logic [9:0] IDX_ZD_CTRL = 10'h01E;
    localparam logic [9:0] IDX_STATUS = 10'h01F;
    localparam logic [9:0] IDX_POST_DIV = 10'h1E0;
    localparam logic [9:0] IDX_UPDATE = 10'h232;
    localparam logic [9:0] IDX_R_DIV = 10'h040;
    localparam logic [9:0] IDX_DELAY = 10'h041;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int START_BIT = 0;
    localparam int CAL_DIV_LSB = 1;
    localparam int BUSY_BIT = 0;
    localparam int DONE_BIT = 6;
    localparam int ZD_MODE_LSB = 1;
    localparam int FB_SEL_LSB = 3;
    localparam int UPDATE_BIT = 0;
    localparam int N_DELAY_LSB = 4;
    // ----------------------------------------
    // Encodings and reset values
    // ----------------------------------------
    localparam logic [1:0] ZD_INTERNAL = 2'h1;
    localparam logic [1:0] ZD_EXTERNAL = 2'h3;
    localparam logic [1:0] CAL_DIV_RST = 2'h0;
    localparam logic [1:0] ZD_MODE_RST = 2'h0;
    localparam logic [1:0] FB_SEL_RST = 2'h0;
    localparam logic [2:0] POST_DIV_RST = 3'h2;
    localparam logic [7:0] R_DIV_RST = 8'h01;
    localparam logic [7:0] DELAY_RST = 8'h00;
    localparam logic [7:0] CAL_DIV_BASE = 8'h02;
    localparam int NUM_CHAN = 4;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CAL_CYCLES = 4400;
    localparam int CAL_CNT_W = 13;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_CAL,
        ST_RELEASE,
        ST_CLOSE
    } cal_state_t;
endpackage

//--- logic/tick_divider.sv
`timescale 1ns/1ps
module tick_divider (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [7:0] ratio_i,
    output logic tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } div_state_t;
    div_state_t st;
    div_state_t next_st;
    // ----------------------------------------
    // One output tick per ratio input ticks
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (clear_i) begin
            next_st.cnt = 8'h00;
        end else if (tick_i) begin
            if (ratio_i <= 8'h01 || st.cnt >= ratio_i - 8'h01) begin
                next_st.cnt = 8'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 8'h01;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
    assign tick_o = st.tick;
endmodule // tick_divider

//--- logic/feedback_router.sv
`timescale 1ns/1ps
module feedback_router (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [1:0] mode_i,
    input wire logic [3:0] chan_clk_i,
    input wire logic ext_clk_i,
    output logic fb_o,
    output logic internal_o,
    output logic external_o
);
    typedef struct packed {
        logic fb;
        logic internal;
        logic external;
    } route_state_t;
    route_state_t st;
    route_state_t next_st;
    // ----------------------------------------
    // Feedback path toward the N divider
    // ----------------------------------------
    always_comb begin
        next_st = '0;
        next_st.internal = (mode_i == vcal_pkg::ZD_INTERNAL);
        next_st.external = (mode_i == vcal_pkg::ZD_EXTERNAL);
        if (next_st.internal) begin
            next_st.fb = chan_clk_i[0];
        end else if (next_st.external) begin
            next_st.fb = ext_clk_i;
        end
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
    assign fb_o = st.fb;
    assign internal_o = st.internal;
    assign external_o = st.external;
endmodule // feedback_router

//--- logic/vco_calibration_zero_delay_ctrl.sv
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - First calibration: set start bit once
// - Later: clear, update, set, update
// - Done readback bit shows finished calibration
// - Hold outputs, calibrate, release, close loop
// - Release without waiting for loop settle
// - Calibration clock is compare clock divided
// - Calibration lasts fixed calibration clock count
// - No self start on divider changes
// - Mode 01 routes divider 0 back
// - Mode 11 takes feedback from external input
// - Feedback select names divider, default 0
// - Channel dividers kept aligned together
// - Programmable R and N path delays
// - Calibration advances on reference input only
module vco_calibration_zero_delay_ctrl #(
    parameter int CAL_CYCLES = vcal_pkg::CAL_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reference_input_i,
    input wire logic [3:0] chan_clk_i,
    input wire logic ext_clk_i,
    output logic [3:0] sync_hold_o,
    output logic divider_align_o,
    output logic loop_closed_o,
    output logic cal_busy_o,
    output logic feedback_o,
    output logic zd_internal_o,
    output logic zd_external_o,
    output logic [1:0] fb_select_o,
    output logic [2:0] post_div_o,
    output logic [3:0] r_delay_o,
    output logic [3:0] n_delay_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic w_start;
        logic [1:0] w_cal_div;
        logic [1:0] w_zd_mode;
        logic [1:0] w_fb_sel;
        logic [7:0] w_r_div;
        logic [7:0] w_delay;
        logic a_start;
        logic [1:0] a_cal_div;
        logic [1:0] a_zd_mode;
        logic [1:0] a_fb_sel;
        logic [7:0] a_r_div;
        logic [7:0] a_delay;
        logic [2:0] post_div;
        logic start_prev;
        vcal_pkg::cal_state_t fsm;
        logic [12:0] cnt;
        logic done;
        logic busy;
        logic [3:0] hold;
        logic align;
        logic loop_closed;
        logic ref_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctrl_state_t;
    ctrl_state_t st;
    ctrl_state_t next_st;
    logic compare_tick;
    logic cal_tick;
    logic ref_rise;
    logic [9:0] idx;
    logic setup;
    logic wr_now;
    logic launch;
    logic [3:0] keep_running;
    // ----------------------------------------
    // Clock derivation from the reference input
    // ----------------------------------------
    assign ref_rise = reference_input_i & ~st.ref_prev;
    tick_divider u_r_div (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(1'b0),
        .tick_i(ref_rise),
        .ratio_i(st.a_r_div),
        .tick_o(compare_tick)
    );
    tick_divider u_cal_div (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(st.fsm == vcal_pkg::ST_HOLD),
        .tick_i(compare_tick),
        .ratio_i(vcal_pkg::CAL_DIV_BASE << st.a_cal_div),
        .tick_o(cal_tick)
    );
    // ----------------------------------------
    // Zero-delay feedback routing
    // ----------------------------------------
    feedback_router u_route (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .mode_i(st.a_zd_mode),
        .chan_clk_i(chan_clk_i),
        .ext_clk_i(ext_clk_i),
        .fb_o(feedback_o),
        .internal_o(zd_internal_o),
        .external_o(zd_external_o)
    );
    // ----------------------------------------
    // Per-channel hold mask
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < vcal_pkg::NUM_CHAN; gi++) begin : g_chan
            assign keep_running[gi] = (st.a_zd_mode == vcal_pkg::ZD_EXTERNAL)
                && (st.a_fb_sel == 2'(gi));
        end
    endgenerate
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign idx = paddr[11:2];
    assign setup = psel & ~penable;
    assign wr_now = psel & penable & st.pready & pwrite & pstrb[0];
    // Only a committed 0 to 1 of start launches
    assign launch = st.a_start & ~st.start_prev;
    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.ref_prev = reference_input_i;
        next_st.align = 1'b0;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        // Read data and answer prepared in the setup cycle
        if (setup) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            case (idx)
                vcal_pkg::IDX_CAL_CTRL: begin
                    next_st.prdata[vcal_pkg::START_BIT] = st.w_start;
                    next_st.prdata[vcal_pkg::CAL_DIV_LSB +: 2] = st.w_cal_div;
                end
                vcal_pkg::IDX_ZD_CTRL: begin
                    next_st.prdata[vcal_pkg::ZD_MODE_LSB +: 2] = st.w_zd_mode;
                    next_st.prdata[vcal_pkg::FB_SEL_LSB +: 2] = st.w_fb_sel;
                end
                vcal_pkg::IDX_STATUS: begin
                    next_st.prdata[vcal_pkg::DONE_BIT] = st.done;
                    next_st.prdata[vcal_pkg::BUSY_BIT] = st.busy;
                end
                vcal_pkg::IDX_POST_DIV: begin
                    next_st.prdata[2:0] = st.post_div;
                end
                vcal_pkg::IDX_UPDATE: begin
                    next_st.prdata = 32'h0000_0000;
                end
                vcal_pkg::IDX_R_DIV: begin
                    next_st.prdata[7:0] = st.w_r_div;
                end
                vcal_pkg::IDX_DELAY: begin
                    next_st.prdata[7:0] = st.w_delay;
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        // Writes land in the shadow copies, except post_div, which takes effect at once
        if (wr_now) begin
            case (idx)
                vcal_pkg::IDX_CAL_CTRL: begin
                    next_st.w_start = pwdata[vcal_pkg::START_BIT];
                    next_st.w_cal_div = pwdata[vcal_pkg::CAL_DIV_LSB +: 2];
                end
                vcal_pkg::IDX_ZD_CTRL: begin
                    next_st.w_zd_mode = pwdata[vcal_pkg::ZD_MODE_LSB +: 2];
                    next_st.w_fb_sel = pwdata[vcal_pkg::FB_SEL_LSB +: 2];
                end
                vcal_pkg::IDX_POST_DIV: begin
                    next_st.post_div = pwdata[2:0];
                end
                vcal_pkg::IDX_R_DIV: begin
                    next_st.w_r_div = pwdata[7:0];
                end
                vcal_pkg::IDX_DELAY: begin
                    next_st.w_delay = pwdata[7:0];
                end
                vcal_pkg::IDX_UPDATE: begin
                    // Commit all shadow settings at once
                    if (pwdata[vcal_pkg::UPDATE_BIT]) begin
                        next_st.a_start = st.w_start;
                        next_st.a_cal_div = st.w_cal_div;
                        next_st.a_zd_mode = st.w_zd_mode;
                        next_st.a_fb_sel = st.w_fb_sel;
                        next_st.a_r_div = st.w_r_div;
                        next_st.a_delay = st.w_delay;
                    end
                end
                default: begin
                end
            endcase
        end
        // Edge tracking of the committed start bit
        next_st.start_prev = st.a_start;
        // Calibration sequencer
        case (st.fsm)
            vcal_pkg::ST_IDLE: begin
                if (launch) begin
                    next_st.fsm = vcal_pkg::ST_HOLD;
                    next_st.hold = ~keep_running;
                    next_st.done = 1'b0;
                    next_st.busy = 1'b1;
                    next_st.loop_closed = 1'b0;
                end
            end
            vcal_pkg::ST_HOLD: begin
                next_st.cnt = 13'h0000;
                next_st.fsm = vcal_pkg::ST_CAL;
            end
            vcal_pkg::ST_CAL: begin
                // Advances only on calibration clock ticks
                if (cal_tick) begin
                    if (st.cnt == 13'(CAL_CYCLES - 1)) begin
                        next_st.fsm = vcal_pkg::ST_RELEASE;
                    end else begin
                        next_st.cnt = st.cnt + 13'h0001;
                    end
                end
            end
            vcal_pkg::ST_RELEASE: begin
                // Outputs resume right away, no settle wait
                next_st.hold = 4'h0;
                next_st.align = 1'b1;
                next_st.fsm = vcal_pkg::ST_CLOSE;
            end
            vcal_pkg::ST_CLOSE: begin
                next_st.loop_closed = 1'b1;
                next_st.done = 1'b1;
                next_st.busy = 1'b0;
                next_st.fsm = vcal_pkg::ST_IDLE;
            end
            default: begin
                next_st.fsm = vcal_pkg::ST_IDLE;
                next_st.hold = 4'h0;
                next_st.busy = 1'b0;
            end
        endcase
    end
    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
            st.fsm <= vcal_pkg::ST_IDLE;
            st.w_cal_div <= vcal_pkg::CAL_DIV_RST;
            st.a_cal_div <= vcal_pkg::CAL_DIV_RST;
            st.w_zd_mode <= vcal_pkg::ZD_MODE_RST;
            st.a_zd_mode <= vcal_pkg::ZD_MODE_RST;
            st.w_fb_sel <= vcal_pkg::FB_SEL_RST;
            st.a_fb_sel <= vcal_pkg::FB_SEL_RST;
            st.w_r_div <= vcal_pkg::R_DIV_RST;
            st.a_r_div <= vcal_pkg::R_DIV_RST;
            st.w_delay <= vcal_pkg::DELAY_RST;
            st.a_delay <= vcal_pkg::DELAY_RST;
            st.post_div <= vcal_pkg::POST_DIV_RST;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign sync_hold_o = st.hold;
    assign divider_align_o = st.align;
    assign loop_closed_o = st.loop_closed;
    assign cal_busy_o = st.busy;
    assign fb_select_o = st.a_fb_sel;
    assign post_div_o = st.post_div;
    assign r_delay_o = st.a_delay[3:0];
    assign n_delay_o = st.a_delay[vcal_pkg::N_DELAY_LSB +: 4];
endmodule // vco_calibration_zero_delay_ctrl

//--- tb/vcal_properties.sv
`timescale 1ns/1ps
module vcal_properties #(
    parameter int CAL_CYCLES = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic reference_input_i,
    input wire logic [3:0] chan_clk_i,
    input wire logic ext_clk_i,
    input wire logic [3:0] sync_hold_o,
    input wire logic divider_align_o,
    input wire logic loop_closed_o,
    input wire logic cal_busy_o,
    input wire logic feedback_o,
    input wire logic zd_internal_o,
    input wire logic zd_external_o,
    input wire logic [1:0] fb_select_o
);
    localparam int MIN_REF = 2 * CAL_CYCLES - 2;
    localparam logic [11:0] UPD_ADDR = {vcal_pkg::IDX_UPDATE, 2'b00};
    logic [3:0] upd_age;
    logic [15:0] ref_cnt;
    logic ref_q;
    always_ff @(posedge clock_i) begin
        ref_q <= reference_input_i;
        if (rst_i) begin
            upd_age <= 4'hF;
        end else if (psel && penable && pwrite && paddr == UPD_ADDR && pwdata[0]) begin
            upd_age <= 4'h0;
        end else if (upd_age != 4'hF) begin
            upd_age <= upd_age + 4'h1;
        end
        if (!cal_busy_o) begin
            ref_cnt <= 16'h0;
        end else if (reference_input_i && !ref_q) begin
            ref_cnt <= ref_cnt + 16'h1;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_hold_on_start; $rose(cal_busy_o) |-> (|sync_hold_o) && !loop_closed_o; endproperty
    a_hold_on_start: assert property (p_hold_on_start) else $error("no hold at start");
    property p_launch_cause; $rose(cal_busy_o) |-> upd_age < 4'h5; endproperty
    a_launch_cause: assert property (p_launch_cause) else $error("start without update");
    property p_release; $fell(|sync_hold_o) |-> divider_align_o ##1 (loop_closed_o && !cal_busy_o); endproperty
    a_release: assert property (p_release) else $error("release order wrong");
    property p_align; divider_align_o |-> !(|sync_hold_o) && $past(|sync_hold_o); endproperty
    a_align: assert property (p_align) else $error("align without release");
    property p_cal_len; $fell(cal_busy_o) |-> ref_cnt >= MIN_REF; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration too short");
    property p_zd_int; (zd_internal_o && chan_clk_i[0]) [*3] |-> feedback_o; endproperty
    a_zd_int: assert property (p_zd_int) else $error("internal feedback wrong");
    property p_zd_ext; (zd_external_o && ext_clk_i) [*3] |-> feedback_o; endproperty
    a_zd_ext: assert property (p_zd_ext) else $error("external feedback wrong");
    property p_zd_off; (!zd_internal_o && !zd_external_o) [*2] |-> !feedback_o; endproperty
    a_zd_off: assert property (p_zd_off) else $error("feedback while off");
    property p_ext_mask; zd_external_o && cal_busy_o && (|sync_hold_o) |-> !sync_hold_o[fb_select_o]; endproperty
    a_ext_mask: assert property (p_ext_mask) else $error("feedback channel held");
    c_start: cover property ($rose(cal_busy_o));
    c_align: cover property (divider_align_o);
    c_ext_cal: cover property (zd_external_o && cal_busy_o);
endmodule // vcal_properties

//--- tb/vcal_host_model.sv
`timescale 1ns/1ps
module vcal_host_model (
    input wire logic clock_i,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    localparam logic [11:0] A_CAL = {vcal_pkg::IDX_CAL_CTRL, 2'b00};
    localparam logic [11:0] A_UPD = {vcal_pkg::IDX_UPDATE, 2'b00};
    logic [31:0] rd_data;
    logic rd_err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    // Clear, commit, set, commit
    task automatic cal_restart(input logic [1:0] div);
        xfer(1'b1, A_CAL, {29'h0, div, 1'b0});
        xfer(1'b1, A_UPD, 32'h1);
        xfer(1'b1, A_CAL, {29'h0, div, 1'b1});
        xfer(1'b1, A_UPD, 32'h1);
    endtask
endmodule // vcal_host_model

//--- tb/vco_calibration_zero_delay_ctrl_bench.sv
`timescale 1ns/1ps
module vco_calibration_zero_delay_ctrl_bench;
    localparam int CALN = 8;
    localparam logic [11:0] A_CAL = {vcal_pkg::IDX_CAL_CTRL, 2'b00};
    localparam logic [11:0] A_ZD = {vcal_pkg::IDX_ZD_CTRL, 2'b00};
    localparam logic [11:0] A_ST = {vcal_pkg::IDX_STATUS, 2'b00};
    localparam logic [11:0] A_PD = {vcal_pkg::IDX_POST_DIV, 2'b00};
    localparam logic [11:0] A_UPD = {vcal_pkg::IDX_UPDATE, 2'b00};
    localparam logic [11:0] A_R = {vcal_pkg::IDX_R_DIV, 2'b00};
    localparam logic [11:0] A_DLY = {vcal_pkg::IDX_DELAY, 2'b00};
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ref_on = 1'b1;
    logic reference_input_i = 1'b0;
    logic [3:0] chan_clk_i = 4'h0;
    logic ext_clk_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, divider_align_o, loop_closed_o, cal_busy_o;
    logic feedback_o, zd_internal_o, zd_external_o;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, sync_hold_o, r_delay_o, n_delay_o;
    logic [1:0] fb_select_o;
    logic [2:0] post_div_o;
    int n_mismatch = 0;
    int total_checks = 0;
    int ref_rises = 0;
    int e;
    logic [11:0] ra[7] = '{A_ST, A_R, A_DLY, A_PD, A_UPD, A_CAL, A_ZD};
    logic [31:0] rv[7] = '{32'h0, 32'h1, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
    always #4 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        chan_clk_i <= 4'($urandom);
        ext_clk_i <= 1'($urandom);
        reference_input_i <= ref_on & ~reference_input_i;
        if (cal_busy_o === 1'b1 && ref_on && !reference_input_i) ref_rises++;
    end
    vco_calibration_zero_delay_ctrl #(.CAL_CYCLES(CALN)) vco_calibration_zero_delay_ctrl_inst (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_input_i(reference_input_i), .chan_clk_i(chan_clk_i), .ext_clk_i(ext_clk_i),
        .sync_hold_o(sync_hold_o), .divider_align_o(divider_align_o), .loop_closed_o(loop_closed_o),
        .cal_busy_o(cal_busy_o), .feedback_o(feedback_o), .zd_internal_o(zd_internal_o),
        .zd_external_o(zd_external_o), .fb_select_o(fb_select_o), .post_div_o(post_div_o),
        .r_delay_o(r_delay_o), .n_delay_o(n_delay_o));
    vcal_host_model host_inst (.clock_i(clock_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ----------------------------------------
    // Compare and wait helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        host_inst.xfer(1'b0, a, 32'h0);
        check(host_inst.rd_data, exp);
    endtask
    task automatic wait_busy(input logic lvl);
        for (int k = 0; k < 3000 && cal_busy_o !== lvl; k++) @(posedge clock_i);
        check(32'(cal_busy_o), 32'(lvl));
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(1766));
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(32'({sync_hold_o, cal_busy_o, loop_closed_o, fb_select_o, post_div_o}), 32'h2);
        for (int k = 0; k < 7; k++) rd(ra[k], rv[k]);
        rd(12'hFFC, 32'h0);
        check(32'(host_inst.rd_err), 32'h1);
        host_inst.xfer(1'b1, A_CAL, 32'h1);
        host_inst.xfer(1'b1, A_ZD, 32'h1E);
        host_inst.xfer(1'b1, A_PD, 32'h3);
        @(posedge clock_i);
        check(32'(post_div_o), 32'h3);
        host_inst.xfer(1'b1, A_DLY, 32'hA5);
        repeat (4) @(posedge clock_i);
        check(32'({cal_busy_o, fb_select_o, r_delay_o}), 32'h0);
        ref_rises = 0;
        host_inst.xfer(1'b1, A_UPD, 32'h1);
        wait_busy(1'b1);
        rd(A_ST, 32'h1);
        check(32'({zd_external_o, fb_select_o, n_delay_o, r_delay_o}), 32'h7A5);
        wait_busy(1'b0);
        check_rng(ref_rises, 2 * CALN - 2, 2 * CALN + 4);
        rd(A_ST, 32'h40);
        host_inst.xfer(1'b1, A_R, 32'h2);
        host_inst.xfer(1'b1, A_UPD, 32'h1);
        repeat (20) @(posedge clock_i);
        check(32'({cal_busy_o, loop_closed_o}), 32'h1);
        for (int d = 0; d < 4; d++) begin
            // Each calibration divider setting, alternating internal and external mode
            host_inst.xfer(1'b1, A_ZD, d[0] ? {27'h0, 2'($urandom), 3'h6} : 32'h2);
            ref_rises = 0;
            host_inst.cal_restart(d[1:0]);
            wait_busy(1'b1);
            check(32'({zd_internal_o, zd_external_o}), d[0] ? 32'h1 : 32'h2);
            rd(A_ST, 32'h1);
            wait_busy(1'b0);
            e = CALN * 2 * (2 << d);
            check_rng(ref_rises, e - 2, e + 4);
        end
        ref_on <= 1'b0;
        host_inst.cal_restart(2'h0);
        wait_busy(1'b1);
        repeat (200) @(posedge clock_i);
        check(32'(cal_busy_o), 32'h1);
        ref_on <= 1'b1;
        wait_busy(1'b0);
        rd(A_ST, 32'h40);
        host_inst.cal_restart(2'h3);
        wait_busy(1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(32'({sync_hold_o, cal_busy_o, loop_closed_o, fb_select_o, post_div_o}), 32'h2);
        final_report();
    end
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule // vco_calibration_zero_delay_ctrl_bench
bind vco_calibration_zero_delay_ctrl vcal_properties #(.CAL_CYCLES(CAL_CYCLES)) vcal_properties_inst (
    .clock_i(clock_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .reference_input_i(reference_input_i), .chan_clk_i(chan_clk_i), .ext_clk_i(ext_clk_i),
    .sync_hold_o(sync_hold_o), .divider_align_o(divider_align_o), .loop_closed_o(loop_closed_o),
    .cal_busy_o(cal_busy_o), .feedback_o(feedback_o), .zd_internal_o(zd_internal_o),
    .zd_external_o(zd_external_o), .fb_select_o(fb_select_o));
